// *** aoc_ctrl.sv ***
// analog output channel control: scheduler, calibration and Avalon-MM registers
// assumes a DAC that takes one code per dac_load pulse; one clock, sync reset
//
// Overview of operation
// - convert a channel only while enabled; disabled channels are skipped entirely.
// - full cycle equals one channel conversion time times enabled channel count.
// - every channel enable is off after reset until software sets it.
// - DAC code is data times gain divided by 65535 plus offset.
// - separate offset and gain per range per channel; selected range's pair applies.
// - offset limited to 16383 or 32000 by variant; gain limited to 100000.
// - factory calibration is fixed and reloaded on a restore request.
// - 14-bit and 16-bit variants clamp input data to their own scopes.
// - each channel selects voltage or current range independently.
// - an unconfigured channel defaults to the 0 to 10 V range.
`timescale 1ns/100ps
module aoc_ctrl #(
    parameter bit HIGH_RES = 1'b0,
    parameter int CONV_CYCLES = aoc_pkg::CONV_CYC,
    parameter int FACT_OFFSET = aoc_pkg::FACT_OFFSET_DEF,
    parameter int FACT_GAIN = aoc_pkg::FACT_GAIN_DEF
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [aoc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic signed [aoc_pkg::DAC_W-1:0] dac_code,
    output logic [aoc_pkg::CH_W-1:0] dac_channel,
    output aoc_pkg::aoc_range_t dac_range,
    output logic dac_current,
    output logic dac_load
);
    import aoc_pkg::*;

    localparam int OFF_LIM = HIGH_RES ? HI_OFF_LIM : STD_OFF_LIM;
    localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                 input int lo, input int hi);
        clamp = (v < lo) ? 32'(lo) : (v > hi) ? 32'(hi) : v;
    endfunction : clamp

    function automatic logic is_bipolar(input aoc_range_t r);
        is_bipolar = (r == RNG_PM10V) || (r == RNG_PM5V);
    endfunction : is_bipolar

    function automatic logic signed [31:0] scale_data(input logic signed [31:0] v,
                                                      input aoc_range_t r);
        if (HIGH_RES) begin
            scale_data = clamp(v, is_bipolar(r) ? -HI_LIM : 0, HI_LIM);
        end else begin
            scale_data = is_bipolar(r) ? clamp(v, STD_BI_LO, STD_BI_HI)
                                       : clamp(v, 0, STD_UNI_HI);
        end
    endfunction : scale_data

    // returns {found, channel}: first enabled channel after cur, wrapping
    function automatic logic [CH_W:0] next_ch(input logic [NUM_CH-1:0] en,
                                              input logic [CH_W-1:0] cur);
        logic [CH_W-1:0] c;
        next_ch = '0;
        for (int i = NUM_CH; i >= 1; i--) begin
            c = CH_W'((int'(cur) + i) % NUM_CH);
            if (en[c]) begin
                next_ch = {1'b1, c};
            end
        end
    endfunction : next_ch

    function automatic int cal_idx(input logic [CH_W-1:0] ch, input aoc_range_t r);
        cal_idx = int'(ch) * NUM_RANGE + int'(r);
    endfunction : cal_idx

    function automatic logic signed [DAC_W-1:0] calc(input logic signed [DATA_W-1:0] d,
                                                     input logic signed [GAIN_W-1:0] g,
                                                     input logic signed [OFF_W-1:0] o);
        logic signed [39:0] prod;
        prod = 40'(d) * 40'(g);
        calc = DAC_W'(prod / CAL_DIV + 40'(o));
    endfunction : calc

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [NUM_CH-1:0] chan_en_q, chan_en_d;
    logic signed [DATA_W-1:0] data_q [NUM_CH];
    logic signed [DATA_W-1:0] data_d [NUM_CH];
    aoc_range_t range_q [NUM_CH];
    aoc_range_t range_d [NUM_CH];
    logic signed [OFF_W-1:0] off_q [NUM_CAL];
    logic signed [OFF_W-1:0] off_d [NUM_CAL];
    logic signed [GAIN_W-1:0] gain_q [NUM_CAL];
    logic signed [GAIN_W-1:0] gain_d [NUM_CAL];
    logic [CH_W-1:0] sel_ch_q, sel_ch_d;
    aoc_range_t sel_rng_q, sel_rng_d;
    aoc_state_t state_q, state_d;
    logic [CH_W-1:0] cur_q, cur_d;
    logic [15:0] timer_q, timer_d;
    logic signed [DAC_W-1:0] code_q, code_d;
    logic [CH_W-1:0] chan_q, chan_d;
    aoc_range_t drng_q, drng_d;
    logic load_q, load_d;

    logic wr_acc, rd_take, slot_en;
    logic [CH_W:0] nxt;
    logic signed [31:0] wd_s;
    logic signed [DAC_W-1:0] expect_code;
    aoc_range_t cur_rng;
    int sel_i;

    assign wd_s = avs_writedata;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_acc = avs_write & ack_q;
    assign rd_take = avs_read & ~ack_q;
    assign slot_en = chan_en_q[cur_q];
    assign cur_rng = range_q[cur_q];
    assign sel_i = cal_idx(sel_ch_q, sel_rng_q);
    assign expect_code = calc(data_q[cur_q], gain_q[cal_idx(cur_q, cur_rng)],
                              off_q[cal_idx(cur_q, cur_rng)]);

    assign avs_readdata = rdata_q;
    assign dac_code = code_q;
    assign dac_channel = chan_q;
    assign dac_range = drng_q;
    assign dac_current = (drng_q == RNG_0_20MA) || (drng_q == RNG_4_20MA);
    assign dac_load = load_q;

    // ----------------------------------------
    // register access
    // ----------------------------------------
    always_comb begin
        ack_d = (avs_read | avs_write) & ~ack_q;
        rdata_d = rdata_q;
        chan_en_d = chan_en_q;
        data_d = data_q;
        range_d = range_q;
        off_d = off_q;
        gain_d = gain_q;
        sel_ch_d = sel_ch_q;
        sel_rng_d = sel_rng_q;
        if (rd_take) begin
            rdata_d = '0;
            case (avs_address & REG_GRP_MASK)
                REG_DATA0: rdata_d = 32'(data_q[avs_address[3:2]]);
                REG_RANGE0: rdata_d = 32'(range_q[avs_address[3:2]]);
                default: begin
                    case (avs_address)
                        REG_CTRL: rdata_d[CTRL_EN_LSB +: NUM_CH] = chan_en_q;
                        REG_STATUS: begin
                            rdata_d[STS_CUR_LSB +: CH_W] = cur_q;
                            rdata_d[STS_BUSY_BIT] = (state_q == ST_CONV);
                            rdata_d[STS_NEN_LSB +: 3] = 3'($countones(chan_en_q));
                        end
                        REG_CAL_SEL: begin
                            rdata_d[CALSEL_CH_LSB +: CH_W] = sel_ch_q;
                            rdata_d[CALSEL_RNG_LSB +: 3] = sel_rng_q;
                        end
                        REG_CAL_OFF: rdata_d = 32'(off_q[sel_i]);
                        REG_CAL_GAIN: rdata_d = 32'(gain_q[sel_i]);
                        REG_DAC_CODE: rdata_d = 32'(code_q);
                        default: rdata_d = '0;
                    endcase
                end
            endcase
        end
        if (wr_acc) begin
            case (avs_address & REG_GRP_MASK)
                REG_DATA0: data_d[avs_address[3:2]] =
                    DATA_W'(scale_data(wd_s, range_q[avs_address[3:2]]));
                REG_RANGE0: begin
                    if (int'(avs_writedata[2:0]) < NUM_RANGE) begin
                        range_d[avs_address[3:2]] = aoc_range_t'(avs_writedata[2:0]);
                    end
                end
                default: begin
                    case (avs_address)
                        REG_CTRL: begin
                            chan_en_d = avs_writedata[CTRL_EN_LSB +: NUM_CH];
                            if (avs_writedata[CTRL_RESTORE_BIT]) begin
                                for (int i = 0; i < NUM_CAL; i++) begin
                                    off_d[i] = OFF_W'(FACT_OFFSET);
                                    gain_d[i] = GAIN_W'(FACT_GAIN);
                                end
                            end
                        end
                        REG_CAL_SEL: begin
                            sel_ch_d = avs_writedata[CALSEL_CH_LSB +: CH_W];
                            if (int'(avs_writedata[CALSEL_RNG_LSB +: 3]) < NUM_RANGE) begin
                                sel_rng_d = aoc_range_t'(avs_writedata[CALSEL_RNG_LSB +: 3]);
                            end
                        end
                        REG_CAL_OFF: off_d[sel_i] = OFF_W'(clamp(wd_s, -OFF_LIM, OFF_LIM));
                        REG_CAL_GAIN: gain_d[sel_i] =
                            GAIN_W'(clamp(wd_s, -GAIN_LIM, GAIN_LIM));
                        default: ;
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
            chan_en_q <= '0;
            sel_ch_q <= '0;
            sel_rng_q <= RNG_DEFAULT;
            for (int i = 0; i < NUM_CH; i++) begin
                data_q[i] <= '0;
                range_q[i] <= RNG_DEFAULT;
            end
            for (int i = 0; i < NUM_CAL; i++) begin
                off_q[i] <= OFF_W'(FACT_OFFSET);
                gain_q[i] <= GAIN_W'(FACT_GAIN);
            end
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            chan_en_q <= chan_en_d;
            data_q <= data_d;
            range_q <= range_d;
            off_q <= off_d;
            gain_q <= gain_d;
            sel_ch_q <= sel_ch_d;
            sel_rng_q <= sel_rng_d;
        end
    end

    // ----------------------------------------
    // conversion scheduler
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        cur_d = cur_q;
        timer_d = timer_q;
        code_d = code_q;
        chan_d = chan_q;
        drng_d = drng_q;
        load_d = 1'b0;
        nxt = next_ch(chan_en_q, cur_q);
        case (state_q)
            ST_IDLE: begin
                nxt = next_ch(chan_en_q, CH_W'(NUM_CH - 1));
                if (nxt[CH_W]) begin
                    state_d = ST_CONV;
                    cur_d = nxt[CH_W-1:0];
                    timer_d = CONV_LAST;
                end
            end
            ST_CONV: begin
                if (!slot_en || timer_q == '0) begin
                    if (slot_en) begin
                        load_d = 1'b1;
                        code_d = expect_code;
                        chan_d = cur_q;
                        drng_d = cur_rng;
                    end
                    if (nxt[CH_W]) begin
                        cur_d = nxt[CH_W-1:0];
                        timer_d = CONV_LAST;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end else begin
                    timer_d = timer_q - 16'h0001;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cur_q <= '0;
            timer_q <= '0;
            code_q <= '0;
            chan_q <= '0;
            drng_q <= RNG_DEFAULT;
            load_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cur_q <= cur_d;
            timer_q <= timer_d;
            code_q <= code_d;
            chan_q <= chan_d;
            drng_q <= drng_d;
            load_q <= load_d;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [15:0] since_q;
    logic stab_q;
    logic [CH_W-1:0] prev_ch_q;
    logic [NUM_CH-1:0] en_seen_q;
    logic signed [39:0] cal_ref;
    logic [CH_W:0] exp_nxt;
    // scaling restated apart from calc, for the code check
    assign cal_ref = 40'(data_q[cur_q]) * 40'(gain_q[cal_idx(cur_q, cur_rng)]) / CAL_DIV
                     + 40'(off_q[cal_idx(cur_q, cur_rng)]);
    assign exp_nxt = next_ch(chan_en_q, prev_ch_q);
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            since_q <= '0;
            stab_q <= 1'b0;
            prev_ch_q <= '0;
            en_seen_q <= '0;
        end else begin
            en_seen_q <= chan_en_q;
            since_q <= load_q ? 16'h0000 : since_q + 16'h0001;
            prev_ch_q <= load_q ? chan_q : prev_ch_q;
            stab_q <= (chan_en_q != en_seen_q) ? 1'b0 : (load_q ? 1'b1 : stab_q);
        end
    end

    property p_skip_disabled;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ST_CONV && !slot_en) |=> !dac_load;
    endproperty
    a_skip_disabled: assert property (p_skip_disabled) else $error("load on disabled channel");

    property p_cycle_len;
        @(posedge mclk) disable iff (sys_rst)
        (dac_load && stab_q && chan_en_q == en_seen_q) |-> since_q == CONV_LAST;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("slot length wrong");

    property p_en_reset;
        @(posedge mclk) $past(sys_rst) && !sys_rst |-> chan_en_q == '0 && range_q[0] == RNG_0_10V;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("reset defaults wrong");

    property p_code;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ST_CONV && slot_en && timer_q == '0) |=>
        dac_load && dac_code == DAC_W'($past(cal_ref));
    endproperty
    a_code: assert property (p_code) else $error("dac code mismatch");

    property p_range_pair;
        @(posedge mclk) disable iff (sys_rst)
        dac_load |-> dac_range == $past(cur_rng) && dac_current == (dac_range >= RNG_0_20MA);
    endproperty
    a_range_pair: assert property (p_range_pair) else $error("range not applied");

    property p_cal_limits;
        @(posedge mclk) disable iff (sys_rst)
        off_q[sel_i] >= -OFF_LIM && off_q[sel_i] <= OFF_LIM &&
        gain_q[sel_i] >= -GAIN_LIM && gain_q[sel_i] <= GAIN_LIM;
    endproperty
    a_cal_limits: assert property (p_cal_limits) else $error("calibration out of range");

    property p_restore;
        @(posedge mclk) disable iff (sys_rst)
        (wr_acc && avs_address == REG_CTRL && avs_writedata[CTRL_RESTORE_BIT]) |=>
        off_q[sel_i] == OFF_W'(FACT_OFFSET) && gain_q[sel_i] == GAIN_W'(FACT_GAIN);
    endproperty
    a_restore: assert property (p_restore) else $error("factory restore failed");

    property p_order;
        @(posedge mclk) disable iff (sys_rst)
        (dac_load && stab_q && chan_en_q == en_seen_q) |->
        dac_channel == exp_nxt[CH_W-1:0];
    endproperty
    a_order: assert property (p_order) else $error("channel order wrong");

endmodule : aoc_ctrl

// *** aoc_dac_model.sv ***
// converter model standing at the dac side of the channel control
// assumes dac_load is a one-cycle strobe with code and channel valid alongside
`timescale 1ns/100ps
module aoc_dac_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic dac_load,
    input wire logic [aoc_pkg::CH_W-1:0] dac_channel,
    input wire logic signed [aoc_pkg::DAC_W-1:0] dac_code,
    output int ld_cnt,
    output logic [aoc_pkg::CH_W-1:0] ld_ch,
    output logic signed [aoc_pkg::DAC_W-1:0] ld_code,
    output int gap
);
    import aoc_pkg::*;
    int cyc;
    int last;

    // ----------------------------------------
    // latch every code handed over, with spacing
    // ----------------------------------------
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (sys_rst) begin
            ld_cnt <= 0;
            last <= cyc;
        end else if (dac_load) begin
            ld_cnt <= ld_cnt + 1;
            ld_ch <= dac_channel;
            ld_code <= dac_code;
            gap <= cyc - last;
            last <= cyc;
        end
    end
endmodule : aoc_dac_model

// *** aoc_pkg.sv ***
// constants, register map and types for the analog output channel control
// assumes a single 200 MHz clock and an Avalon-MM slave port with byte addresses
package aoc_pkg;

    localparam int NUM_CH = 4;
    localparam int NUM_RANGE = 7;
    localparam int NUM_CAL = NUM_CH * NUM_RANGE;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 17;
    localparam int OFF_W = 17;
    localparam int GAIN_W = 18;
    localparam int DAC_W = 20;
    localparam int CH_W = 2;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DATA0 = 8'h10;
    localparam logic [7:0] REG_RANGE0 = 8'h20;
    localparam logic [7:0] REG_CAL_SEL = 8'h30;
    localparam logic [7:0] REG_CAL_OFF = 8'h34;
    localparam logic [7:0] REG_CAL_GAIN = 8'h38;
    localparam logic [7:0] REG_DAC_CODE = 8'h3C;
    localparam logic [7:0] REG_GRP_MASK = 8'hF0;

    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_RESTORE_BIT = 8;
    localparam int STS_CUR_LSB = 0;
    localparam int STS_BUSY_BIT = 4;
    localparam int STS_NEN_LSB = 8;
    localparam int CALSEL_CH_LSB = 0;
    localparam int CALSEL_RNG_LSB = 4;

    // ----------------------------------------
    // output ranges
    // ----------------------------------------
    typedef enum logic [2:0] {
        RNG_PM10V = 3'h0,
        RNG_PM5V = 3'h1,
        RNG_0_10V = 3'h2,
        RNG_0_5V = 3'h3,
        RNG_1_5V = 3'h4,
        RNG_0_20MA = 3'h5,
        RNG_4_20MA = 3'h6
    } aoc_range_t;
    localparam aoc_range_t RNG_DEFAULT = RNG_0_10V;

    // ----------------------------------------
    // calibration and scaling limits
    // ----------------------------------------
    localparam logic signed [39:0] CAL_DIV = 40'sh000000FFFF;
    localparam int STD_OFF_LIM = 16383;
    localparam int HI_OFF_LIM = 32000;
    localparam int GAIN_LIM = 100000;
    localparam int STD_BI_LO = -8192;
    localparam int STD_BI_HI = 8191;
    localparam int STD_UNI_HI = 16383;
    localparam int HI_LIM = 27000;
    localparam int FACT_OFFSET_DEF = 0;
    localparam int FACT_GAIN_DEF = 65535;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int CONV_TIME_NS = 1000;
    localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01
    } aoc_state_t;

endpackage : aoc_pkg

// *** tb_analog_output_channel_control.sv ***
// testbench for the analog output channel control
// assumes one 200 MHz clock and a one-wait-state Avalon-MM slave
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_analog_output_channel_control;
    import aoc_pkg::*;
    localparam int CONV = 4;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic signed [DAC_W-1:0] dac_code;
    logic [CH_W-1:0] dac_channel;
    aoc_range_t dac_range;
    logic dac_current;
    logic dac_load;
    int ld_cnt;
    logic [CH_W-1:0] ld_ch;
    logic signed [DAC_W-1:0] ld_code;
    int gap;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [31:0] rd_hi;
    logic [31:0] hi_readdata;

    aoc_ctrl #(.HIGH_RES(1'b0), .CONV_CYCLES(CONV)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .dac_code(dac_code), .dac_channel(dac_channel),
        .dac_range(dac_range), .dac_current(dac_current), .dac_load(dac_load));
    aoc_dac_model dac (
        .mclk(mclk), .sys_rst(sys_rst), .dac_load(dac_load), .dac_channel(dac_channel),
        .dac_code(dac_code), .ld_cnt(ld_cnt), .ld_ch(ld_ch), .ld_code(ld_code), .gap(gap));
    // 16-bit variant on the same bus, only its read data is checked
    aoc_ctrl #(.HIGH_RES(1'b1), .CONV_CYCLES(CONV)) dut_hi (
        .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(hi_readdata),
        .avs_waitrequest(), .dac_code(), .dac_channel(),
        .dac_range(), .dac_current(), .dac_load());

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    // ----------------------------------------
    // closing report and hang guard
    // ----------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    always @(posedge mclk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            summarize();
        end
    end

    // ----------------------------------------
    // bus cycles: hold until waitrequest seen low
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge mclk);
        end
        rd = avs_readdata;
        rd_hi = hi_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK("register read", e, rd)
    endtask : rd_chk

    task automatic wait_load;
        int start;
        int n;
        start = ld_cnt;
        n = 0;
        while (ld_cnt == start && n < 200) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 200) begin
            `CHK("load arrives", 1, 0)
        end
    endtask : wait_load

    task automatic chk_load(input logic [1:0] ch, input logic signed [19:0] c, input int gp);
        wait_load();
        `CHK("load channel", ch, ld_ch)
        `CHK("load code", c, ld_code)
        if (gp > 0) begin
            `CHK("load spacing", gp, gap)
        end
    endtask : chk_load

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        rd_chk(REG_CTRL, 32'h0);
        rd_chk(REG_RANGE0 + 8'h04, 32'h2);
        rd_chk(8'h08, 32'h0);
        wr_reg(8'h08, 32'hFFFF);
        $display("test reset defaults done");

        wr_reg(REG_RANGE0 + 8'h04, 32'h0);
        wr_reg(REG_DATA0 + 8'h04, 32'hFFFFDCD8);
        rd_chk(REG_DATA0 + 8'h04, 32'hFFFFE000);
        `CHK("high res data", 32'hFFFFDCD8, rd_hi)
        wr_reg(REG_RANGE0 + 8'h04, 32'h2);
        wr_reg(REG_RANGE0 + 8'h04, 32'h7);
        rd_chk(REG_RANGE0 + 8'h04, 32'h2);
        wr_reg(REG_DATA0 + 8'h04, 32'h4E20);
        rd_chk(REG_DATA0 + 8'h04, 32'h3FFF);
        `CHK("high res data", 32'h00004E20, rd_hi)
        wr_reg(REG_DATA0 + 8'h04, 32'hFFFFFFFB);
        rd_chk(REG_DATA0 + 8'h04, 32'h0);
        `CHK("high res data", 32'h0, rd_hi)
        $display("test data scope done");

        wr_reg(REG_DATA0, 32'd1000);
        wr_reg(REG_DATA0 + 8'h08, 32'd2000);
        wr_reg(REG_CTRL, 32'h5);
        chk_load(2'd0, 20'sd1000, 0);
        chk_load(2'd2, 20'sd2000, CONV);
        chk_load(2'd0, 20'sd1000, CONV);
        rd_chk(REG_CTRL, 32'h5);
        bus(1'b0, REG_STATUS, 32'h0);
        `CHK("enabled count", 3'h2, rd[10:8])
        wr_reg(REG_CTRL, 32'h1);
        chk_load(2'd0, 20'sd1000, 0);
        chk_load(2'd0, 20'sd1000, CONV);
        $display("test scheduling done");

        wr_reg(REG_CAL_SEL, 32'h20);
        wr_reg(REG_CAL_OFF, 32'd100);
        wr_reg(REG_CAL_GAIN, 32'h7FFF);
        wait_load();
        chk_load(2'd0, 20'sd599, CONV);
        wr_reg(REG_RANGE0, 32'h5);
        wait_load();
        chk_load(2'd0, 20'sd1000, CONV);
        `CHK("current output", 1'b1, dac_current)
        `CHK("output range", RNG_0_20MA, dac_range)
        wr_reg(REG_RANGE0, 32'h6);
        wait_load();
        chk_load(2'd0, 20'sd1000, CONV);
        `CHK("current output", 1'b1, dac_current)
        wr_reg(REG_RANGE0, 32'h2);
        wait_load();
        chk_load(2'd0, 20'sd599, CONV);
        `CHK("voltage output", 1'b0, dac_current)
        $display("test calibration done");

        wr_reg(REG_CAL_OFF, 32'h4E20);
        rd_chk(REG_CAL_OFF, 32'h3FFF);
        `CHK("high res offset", 32'h00004E20, rd_hi)
        wr_reg(REG_CAL_OFF, 32'hFFFFB1E0);
        rd_chk(REG_CAL_OFF, 32'hFFFFC001);
        `CHK("high res offset", 32'hFFFFB1E0, rd_hi)
        wr_reg(REG_CAL_OFF, 32'h9C40);
        rd_chk(REG_CAL_OFF, 32'h3FFF);
        `CHK("high res offset", 32'h00007D00, rd_hi)
        wr_reg(REG_CAL_GAIN, 32'h30D40);
        rd_chk(REG_CAL_GAIN, 32'h186A0);
        `CHK("high res gain", 32'h000186A0, rd_hi)
        wr_reg(REG_CTRL, 32'h101);
        rd_chk(REG_CAL_OFF, 32'h0);
        rd_chk(REG_CAL_GAIN, 32'hFFFF);
        rd_chk(REG_CTRL, 32'h1);
        wait_load();
        chk_load(2'd0, 20'sd1000, CONV);
        $display("test limits and restore done");

        wr_reg(REG_CTRL, 32'h0);
        wait_load();
        rd = ld_cnt;
        repeat (5 * CONV) @(posedge mclk);
        `CHK("no conversion when disabled", rd, ld_cnt)
        $display("test disable done");
        summarize();
    end
endmodule : tb_analog_output_channel_control
